// [logic/cbd_cfg_store.sv]
`default_nettype none
// eight-entry configuration store, registered read
module cbd_cfg_store #(
  parameter int WORDS = cbd_pkg::CFG_WORDS,
  parameter int WIDTH = cbd_pkg::CFG_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // load port
  input wire logic wr_en,
  input wire logic [$clog2(WORDS)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // read port
  input wire logic [$clog2(WORDS)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  initial begin
    if (WORDS < 2 || WIDTH < 1) $error("cfg store size unsupported");
  end
  typedef struct packed {
    logic [WORDS-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rd;
  } cbd_cfg_st_t;
  cbd_cfg_st_t s_r, s_nxt;

  // write, and registered read of the contents before that write
  always_comb begin
    s_nxt = s_r;
    if (wr_en) begin
      s_nxt.mem[wr_addr] = wr_data; // [RULE1]
    end
    s_nxt.rd = s_r.mem[rd_addr]; // [RULE2]
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rd_data = s_r.rd;
endmodule
`default_nettype wire

// [logic/cbd_datapath.sv]
`default_nettype none
// What this block does
// RULE1: eight configuration words of sixteen bits, each a full operation.
// RULE2: routing inputs pick the configuration word used each cycle.
// RULE3: alu does inc, dec, add, sub, and, or, xor, pass.
// RULE4: pass forwards an operand unchanged to post stage or registers.
// RULE5: separate post stage: shift left, shift right, swap, or mask.
// RULE6: two maskable comparators with selectable register operand pairs.
// RULE7: zero, ones and overflow conditions; selected subset driven out.
// RULE8: programmable msb position for arithmetic and shifts.
// RULE9: one crc or prs step per cycle, programmable polynomial and width.
// RULE10: two four-byte fifos, each input or output buffer.
// RULE11: input mode bus writes fifo; output mode datapath writes fifo.
// RULE12: fifo status selectable as datapath outputs.
// RULE13: carries, shift data and conditions chain to neighbours.
// RULE14: carry and shift out registered, selectable next cycle.
// RULE15: six routing inputs and six routing outputs.
// RULE16: bus-written control register drives routing.
// RULE17: read-only status register shows condition bits 0 to 7, not the selected routing outputs.
// RULE18: status bit may capture a condition until read clears it.
// RULE19: datapath and status/control each have their own clock enable; fifos and config store run without one.
// RULE20: two accumulators, two data registers, two fifos for bus access.
// RULE21: eight-bit alu completes one operation per cycle.
// RULE22: fifo empty and full follow each push or pop from the next clock edge.
module cbd_datapath #(
  parameter int W = cbd_pkg::DATA_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // sub-block enables
  input wire logic dp_en,
  input wire logic sc_en,
  // routing inputs: [2:0] config address, [3] shift in, [4] unused,
  // [5] fifo load strobe
  input wire logic [5:0] route_in,
  // routing outputs
  output logic [5:0] route_out,
  output logic [3:0] out_sel0,
  // output selects, four bits per routing output
  input wire logic [23:0] out_sel,
  // configuration store load
  input wire logic cfg_wr,
  input wire logic [2:0] cfg_addr,
  input wire logic [15:0] cfg_data,
  // static settings
  input wire logic [2:0] msb_pos,
  input wire logic [W-1:0] poly,
  input wire logic [W-1:0] out_mask,
  input wire logic [W-1:0] cmp_mask0,
  input wire logic [W-1:0] cmp_mask1,
  input wire logic cmp_sel0,
  input wire logic cmp_sel1,
  input wire logic fifo_zero_out,
  input wire logic fifo_one_out,
  // working register bus access
  input wire logic wr_en,
  input wire logic [2:0] wr_sel,
  input wire logic [W-1:0] wr_data,
  input wire logic rd_fifo_zero,
  input wire logic rd_fifo_one,
  output logic [W-1:0] accumulator_zero,
  output logic [W-1:0] accumulator_one,
  output logic [W-1:0] data_reg_zero,
  output logic [W-1:0] data_reg_one,
  output logic [W-1:0] fifo_zero_rd,
  output logic [W-1:0] fifo_one_rd,
  // fifo status
  output logic [3:0] fifo_flags,
  // chaining
  input wire logic chain_cin,
  input wire logic chain_sin,
  input wire logic chain_cond_in,
  output logic chain_cout,
  output logic chain_sout,
  output logic chain_cond_out,
  // status and control
  input wire logic [7:0] ctl_wdata,
  input wire logic ctl_wr,
  output logic [7:0] ctl_out,
  input wire logic [7:0] stat_sticky,
  input wire logic stat_rd,
  output logic [7:0] stat_rdata
);
  initial begin
    if (W != 8) $error("datapath width must be eight");
  end
  typedef struct packed {
    logic [W-1:0] acc0, acc1, dat0, dat1;
    logic carry;
    logic sout;
    logic [7:0] ctl;
    logic [7:0] held;
    logic [7:0] srd;
  } cbd_dp_st_t;
  cbd_dp_st_t s_r, s_nxt;

  logic [15:0] cfg;
  logic [W-1:0] fz_out, fo_out;
  logic fz_empty, fz_full, fo_empty, fo_full;
  logic [W-1:0] opa, opb, alu, post, res, msb_mask;
  logic cin, cout, sin, ovf, zero_d, ones_d, cmp0, cmp1, crc_fb;
  logic [W:0] sum;
  logic [15:0] conds;
  logic fz_push, fz_pop, fo_push, fo_pop;

  ////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [W-1:0] pick(input logic [1:0] sel,
                                        input cbd_dp_st_t s);
    case (sel)
      cbd_pkg::SEL_ACC0: pick = s.acc0;
      cbd_pkg::SEL_ACC1: pick = s.acc1;
      cbd_pkg::SEL_DATA0: pick = s.dat0;
      default: pick = s.dat1;
    endcase
  endfunction

  function automatic logic [3:0] sel4(input logic [23:0] v, input int i);
    sel4 = v[i*4 +: 4];
  endfunction

  ////////////////////////////////////////////////////////////////////
  // configuration store, address from routing
  cbd_cfg_store u_cfg (
    .clk(clk),
    .rstn(rstn),
    .wr_en(cfg_wr),
    .wr_addr(cfg_addr),
    .wr_data(cfg_data),
    .rd_addr(route_in[2:0]), // [RULE2] [RULE15]
    .rd_data(cfg)
  );

  // fifo direction: input mode bus pushes, output mode datapath pushes
  always_comb begin
    fz_push = fifo_zero_out ? (dp_en && cfg[11:10] == cbd_pkg::DST_FIFO)
                            : (wr_en && wr_sel == 3'h4); // [RULE11]
    fz_pop = fifo_zero_out ? rd_fifo_zero : (dp_en && route_in[5]);
    fo_push = fifo_one_out ? (dp_en && cfg[11:10] == cbd_pkg::DST_FIFO)
                           : (wr_en && wr_sel == 3'h5); // [RULE11]
    fo_pop = fifo_one_out ? rd_fifo_one : (dp_en && route_in[5]);
  end

  cbd_fifo u_fifo_zero (
    .clk(clk),
    .rstn(rstn),
    .push(fz_push), // [RULE10]
    .push_data(fifo_zero_out ? res : wr_data),
    .pop(fz_pop),
    .pop_data(fz_out),
    .empty(fz_empty),
    .full(fz_full)
  );

  cbd_fifo u_fifo_one (
    .clk(clk),
    .rstn(rstn),
    .push(fo_push), // [RULE10]
    .push_data(fifo_one_out ? res : wr_data),
    .pop(fo_pop),
    .pop_data(fo_out),
    .empty(fo_empty),
    .full(fo_full)
  );

  ////////////////////////////////////////////////////////////////////
  // alu, post stage, msb, crc
  always_comb begin
    msb_mask = W'((9'h002 << msb_pos) - 9'h001); // [RULE8]
    // operands cut at the msb so carry and borrow leave from there
    opa = pick(cfg[4:3], s_r) & msb_mask; // [RULE8]
    opb = pick(cfg[6:5], s_r) & msb_mask;
    case (cfg[13:12])
      cbd_pkg::CIN_ZERO: cin = 1'b0;
      cbd_pkg::CIN_ONE: cin = 1'b1;
      cbd_pkg::CIN_CHAIN: cin = chain_cin; // [RULE13]
      default: cin = s_r.carry; // [RULE14]
    endcase
    sum = '0;
    case (cfg[2:0]) // [RULE3] [RULE21]
      cbd_pkg::OP_INC: sum = {1'b0, opa} + 9'h001;
      cbd_pkg::OP_DEC: sum = {1'b0, opa} - 9'h001;
      cbd_pkg::OP_ADD: sum = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
      cbd_pkg::OP_SUB: sum = {1'b0, opa} - {1'b0, opb} - {8'h00, cin};
      cbd_pkg::OP_AND: sum = {1'b0, opa & opb};
      cbd_pkg::OP_OR: sum = {1'b0, opa | opb};
      cbd_pkg::OP_XOR: sum = {1'b0, opa ^ opb};
      default: sum = {1'b0, opa}; // [RULE4]
    endcase
    alu = sum[W-1:0] & msb_mask;
    cout = (msb_pos == 3'h7) ? sum[W] : sum[msb_pos + 3'h1]; // [RULE8]
    ovf = (opa[msb_pos] == opb[msb_pos]) && (alu[msb_pos] != opa[msb_pos])
          && (cfg[2:0] == cbd_pkg::OP_ADD);
    sin = cfg[15] ? chain_sin : route_in[3]; // [RULE13] [RULE15]
    crc_fb = alu[msb_pos] ^ sin;
    case (cfg[9:7]) // [RULE5]
      cbd_pkg::SH_LEFT: post = {alu[W-2:0], sin};
      cbd_pkg::SH_RIGHT: post = alu >> 1 | (W'(sin) << msb_pos);
      cbd_pkg::SH_SWAP: post = {alu[3:0], alu[7:4]};
      cbd_pkg::SH_ORMASK: post = alu | out_mask;
      default: post = alu;
    endcase
    if (cfg[14]) begin
      post = {alu[W-2:0], 1'b0} ^ (crc_fb ? poly : '0); // [RULE9]
    end
    res = post & msb_mask;
    zero_d = (res == '0); // [RULE7]
    ones_d = (res == msb_mask);
    cmp0 = ((s_r.acc0 ^ (cmp_sel0 ? s_r.dat1 : s_r.dat0))
            & cmp_mask0) == '0; // [RULE6]
    cmp1 = ((s_r.acc1 ^ (cmp_sel1 ? s_r.acc0 : s_r.dat1))
            & cmp_mask1) == '0; // [RULE6]
  end

  // condition vector feeding output selects
  assign conds = {s_r.ctl[3:0], chain_cond_in, s_r.sout, s_r.carry, ovf,
                  fo_full, fo_empty, fz_full, fz_empty, ones_d, zero_d,
                  cmp1, cmp0};

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      route_out[i] = conds[sel4(out_sel, i)]; // [RULE7] [RULE12] [RULE15]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // working registers and status/control
  always_comb begin
    s_nxt = s_r;
    if (dp_en) begin // [RULE19]
      s_nxt.carry = cout; // [RULE14]
      s_nxt.sout = cfg[9:7] == cbd_pkg::SH_RIGHT ? alu[0] : alu[msb_pos];
      case (cfg[11:10])
        cbd_pkg::DST_ACC0: s_nxt.acc0 = res;
        cbd_pkg::DST_ACC1: s_nxt.acc1 = res;
        default: s_nxt.acc0 = s_r.acc0;
      endcase
      if (!fifo_zero_out && route_in[5] && !fz_empty) begin
        s_nxt.dat0 = fz_out; // [RULE11]
      end
      if (!fifo_one_out && route_in[5] && !fo_empty) begin
        s_nxt.dat1 = fo_out;
      end
    end
    if (wr_en) begin // [RULE20]
      case (wr_sel)
        3'h0: s_nxt.acc0 = wr_data;
        3'h1: s_nxt.acc1 = wr_data;
        3'h2: s_nxt.dat0 = wr_data;
        3'h3: s_nxt.dat1 = wr_data;
        default: s_nxt.dat1 = s_nxt.dat1;
      endcase
    end
    if (sc_en) begin // [RULE19]
      if (ctl_wr) begin
        s_nxt.ctl = ctl_wdata; // [RULE16]
      end
      for (int i = 0; i < 8; i++) begin
        // set wins over the read clear
        if (stat_sticky[i]) begin
          s_nxt.held[i] = conds[i] | (stat_rd ? 1'b0 : s_r.held[i]);
        end else begin
          s_nxt.held[i] = conds[i]; // [RULE17]
        end
      end
      if (stat_rd) begin
        s_nxt.srd = s_r.held; // [RULE18]
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs
  assign accumulator_zero = s_r.acc0;
  assign accumulator_one = s_r.acc1;
  assign data_reg_zero = s_r.dat0;
  assign data_reg_one = s_r.dat1;
  assign fifo_zero_rd = fz_out;
  assign fifo_one_rd = fo_out;
  assign fifo_flags = {fo_full, fo_empty, fz_full, fz_empty}; // [RULE12]
  assign chain_cout = s_r.carry; // [RULE13]
  assign chain_sout = s_r.sout;
  assign chain_cond_out = cmp0;
  assign ctl_out = s_r.ctl; // [RULE16]
  assign stat_rdata = s_r.srd;
  assign out_sel0 = sel4(out_sel, 0);

  ////////////////////////////////////////////////////////////////////
  carry_reg_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE14]
    dp_en |=> chain_cout == $past(cout))
    else $error("carry not registered");
  hold_until_read_a: assert property ( // [RULE18]
    @(posedge clk) disable iff (!rstn)
    sc_en && stat_sticky[0] && conds[0] ##1 sc_en && stat_sticky[0]
    && !stat_rd |=> s_r.held[0])
    else $error("held status lost before read");
  ctl_write_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE16]
    sc_en && ctl_wr |=> ctl_out == $past(ctl_wdata))
    else $error("control write lost");
  acc_write_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE20]
    wr_en && wr_sel == 3'h1 |=> accumulator_one == $past(wr_data))
    else $error("accumulator write lost");
  dp_hold_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE19]
    !dp_en && !wr_en |=> $stable(accumulator_zero))
    else $error("datapath ran while disabled");
  zero_out_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE7]
    out_sel[3:0] == 4'h2 |-> route_out[0] == (res == '0))
    else $error("zero condition not routed");
  flags_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE22]
    fz_push && !fz_full |=> !fifo_flags[0])
    else $error("fifo stayed empty after push");
  sum_add_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE3]
    dp_en && cfg[2:0] == cbd_pkg::OP_ADD && cfg[11:10] == cbd_pkg::DST_ACC1
    && cfg[9:7] == cbd_pkg::SH_NONE && !cfg[14] && !wr_en
    |=> accumulator_one == ($past(opa + opb + W'(cin)) & $past(msb_mask)))
    else $error("add result wrong");
endmodule
`default_nettype wire

// [logic/cbd_fifo.sv]
`default_nettype none
// four-byte fifo, status decoded from the registered count
module cbd_fifo #(
  parameter int WIDTH = cbd_pkg::DATA_W,
  parameter int DEPTH = cbd_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // push side
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  // pop side
  input wire logic pop,
  output logic [WIDTH-1:0] pop_data,
  // status
  output logic empty,
  output logic full
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth unsupported");
  end
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } cbd_fifo_st_t;
  cbd_fifo_st_t s_r, s_nxt;
  logic do_push, do_pop;

  assign do_push = push && !full;
  assign do_pop = pop && !empty;

  // pointer and count update
  always_comb begin
    s_nxt = s_r;
    if (do_push) begin
      s_nxt.mem[s_r.wp] = push_data;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (do_pop) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign pop_data = s_r.mem[s_r.rp]; // head word, flip-flop held
  assign empty = (s_r.cnt == '0); // [RULE22]
  assign full = (s_r.cnt == DEPTH[AW:0]); // [RULE22]

  fifo_count_a: assert property (@(posedge clk) disable iff (!rstn) // [RULE22]
    do_push && !do_pop |=> s_r.cnt == $past(s_r.cnt) + 1'b1)
    else $error("fifo count did not rise on push");
endmodule
`default_nettype wire

// [shared/cbd_pkg.sv]
`default_nettype none
package cbd_pkg;
  localparam int DATA_W = 8;
  localparam int CFG_WORDS = 8;
  localparam int CFG_W = 16;
  localparam int FIFO_DEPTH = 4;
  // configuration word field positions
  localparam int F_OP_LSB = 0;     // 3 bits alu op
  localparam int F_SRCA_LSB = 3;   // 2 bits operand a select
  localparam int F_SRCB_LSB = 5;   // 2 bits operand b select
  localparam int F_SHIFT_LSB = 7;  // 3 bits post stage
  localparam int F_DEST_LSB = 10;  // 2 bits destination
  localparam int F_CIN_LSB = 12;   // 2 bits carry in select
  localparam int F_CRC_BIT = 14;   // crc/prs step enable
  localparam int F_SIN_BIT = 15;   // shift in select
  // alu operations
  localparam logic [2:0] OP_PASS = 3'h0;
  localparam logic [2:0] OP_INC = 3'h1;
  localparam logic [2:0] OP_DEC = 3'h2;
  localparam logic [2:0] OP_ADD = 3'h3;
  localparam logic [2:0] OP_SUB = 3'h4;
  localparam logic [2:0] OP_AND = 3'h5;
  localparam logic [2:0] OP_OR = 3'h6;
  localparam logic [2:0] OP_XOR = 3'h7;
  // post stage
  localparam logic [2:0] SH_NONE = 3'h0;
  localparam logic [2:0] SH_LEFT = 3'h1;
  localparam logic [2:0] SH_RIGHT = 3'h2;
  localparam logic [2:0] SH_SWAP = 3'h3;
  localparam logic [2:0] SH_ORMASK = 3'h4;
  // operand and destination selects
  localparam logic [1:0] SEL_ACC0 = 2'h0;
  localparam logic [1:0] SEL_ACC1 = 2'h1;
  localparam logic [1:0] SEL_DATA0 = 2'h2;
  localparam logic [1:0] SEL_DATA1 = 2'h3;
  localparam logic [1:0] DST_NONE = 2'h0;
  localparam logic [1:0] DST_ACC0 = 2'h1;
  localparam logic [1:0] DST_ACC1 = 2'h2;
  localparam logic [1:0] DST_FIFO = 2'h3;
  // carry in select
  localparam logic [1:0] CIN_ZERO = 2'h0;
  localparam logic [1:0] CIN_ONE = 2'h1;
  localparam logic [1:0] CIN_CHAIN = 2'h2;
  localparam logic [1:0] CIN_REG = 2'h3;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_CFG = 16'h0000;
  localparam logic [2:0] RST_MSB = 3'h7;
endpackage
`default_nettype wire

// [tb/cbd_bus_model.sv]
`default_nettype none
// system bus master stand-in: cpu or dma access to the tile
module cbd_bus_model (
  // clock
  input wire logic clk,
  // working registers and fifos
  output logic wr_en,
  output logic [2:0] wr_sel,
  output logic [7:0] wr_data,
  output logic rd_fifo_zero,
  output logic rd_fifo_one,
  // status and control
  output logic [7:0] ctl_wdata,
  output logic ctl_wr,
  output logic stat_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////
  // idle bus at time zero
  initial begin
    wr_en = 1'b0;
    wr_sel = 3'h0;
    wr_data = 8'h00;
    rd_fifo_zero = 1'b0;
    rd_fifo_one = 1'b0;
    ctl_wdata = 8'h00;
    ctl_wr = 1'b0;
    stat_rd = 1'b0;
  end
  ////////////////////////////////////////
  // register write or input fifo push, one cycle
  task automatic wr(input logic [2:0] sel, input logic [7:0] d);
    @(negedge clk);
    wr_en = 1'b1;
    wr_sel = sel;
    wr_data = d;
    @(negedge clk);
    wr_en = 1'b0;
    wr_data = ~d; // released data shows no stale value
  endtask
  // pop of the output fifo
  task automatic pop1();
    @(negedge clk);
    rd_fifo_one = 1'b1;
    @(negedge clk);
    rd_fifo_one = 1'b0;
  endtask
  // control register write
  task automatic ctl(input logic [7:0] d);
    @(negedge clk);
    ctl_wr = 1'b1;
    ctl_wdata = d;
    @(negedge clk);
    ctl_wr = 1'b0;
    ctl_wdata = ~d;
  endtask
  // status read, clears held bits
  task automatic srd();
    @(negedge clk);
    stat_rd = 1'b1;
    @(negedge clk);
    stat_rd = 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`default_nettype none
// bench for the configurable byte datapath
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////
  logic clk, rstn, dp_en, sc_en, cfg_wr, cond, f0o, f1o, cin, sin;
  logic [5:0] route_in, route_out;
  logic [3:0] out_sel0, fifo_flags;
  logic [23:0] out_sel;
  logic [2:0] cfg_addr, msb;
  logic [15:0] cfg_data;
  logic [7:0] acc0, acc1, dat0, dat1, fz_rd, fo_rd, ctl_out, sticky;
  logic ch_cout, ch_sout, ch_cond;
  logic [7:0] stat, poly, omask, cm0, cm1, v;
  logic [7:0] alu_exp [8];
  logic [7:0] sh_exp [4];
  logic cs0, cs1, wr_en, rd0, rd1, ctl_wr, stat_rd;
  logic [2:0] wr_sel;
  logic [7:0] wr_data, ctl_wdata;
  int miscompares, n_tests;
  ////////////////////////////////////////
  // design and bus partner
  cbd_datapath dut_u (
    .clk(clk), .rstn(rstn), .dp_en(dp_en), .sc_en(sc_en),
    .route_in(route_in), .route_out(route_out), .out_sel0(out_sel0),
    .out_sel(out_sel), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
    .cfg_data(cfg_data), .msb_pos(msb), .poly(poly), .out_mask(omask),
    .cmp_mask0(cm0), .cmp_mask1(cm1), .cmp_sel0(cs0), .cmp_sel1(cs1),
    .fifo_zero_out(f0o), .fifo_one_out(f1o), .wr_en(wr_en),
    .wr_sel(wr_sel), .wr_data(wr_data), .rd_fifo_zero(rd0),
    .rd_fifo_one(rd1), .accumulator_zero(acc0), .accumulator_one(acc1),
    .data_reg_zero(dat0), .data_reg_one(dat1), .fifo_zero_rd(fz_rd),
    .fifo_one_rd(fo_rd), .fifo_flags(fifo_flags), .chain_cin(cin),
    .chain_sin(sin), .chain_cond_in(cond), .chain_cout(ch_cout),
    .chain_sout(ch_sout), .chain_cond_out(ch_cond), .ctl_wdata(ctl_wdata),
    .ctl_wr(ctl_wr), .ctl_out(ctl_out), .stat_sticky(sticky),
    .stat_rd(stat_rd), .stat_rdata(stat)
  );
  cbd_bus_model bus_u (
    .clk(clk), .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data),
    .rd_fifo_zero(rd0), .rd_fifo_one(rd1), .ctl_wdata(ctl_wdata),
    .ctl_wr(ctl_wr), .stat_rd(stat_rd)
  );
  ////////////////////////////////////////
  // clock, 5 ns period
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  // config word with carry in zero and no crc step
  function automatic logic [15:0] cw(input logic [2:0] op, sh,
    input logic [1:0] sa, sb, dst);
    cw = {4'h0, dst, sh, sb, sa, op};
  endfunction
  // byte and flag comparisons
  task automatic chk8(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk6(input logic [5:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // configuration word load
  task automatic ld(input logic [2:0] a, input logic [15:0] d);
    @(negedge clk);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_data = d;
    @(negedge clk);
    cfg_wr = 1'b0;
    cfg_data = ~d;
  endtask
  // verdict and end of run
  task automatic stop_test();
    if (miscompares == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // watchdog: the sequence needs about a hundred and fifty cycles
  initial begin
    #20000;
    miscompares++;
    stop_test();
  end
  ////////////////////////////////////////
  // main sequence
  initial begin
    miscompares = 0;
    n_tests = 0;
    rstn = 1'b0;
    {dp_en, sc_en, f1o} = 3'h7;
    {cfg_wr, cond, f0o, cin, sin, cs0, cs1} = 7'h00;
    {route_in, cfg_addr, cfg_data, sticky} = '0;
    {msb, poly, omask, cm0, cm1} = {3'h7, 8'h00, 8'hFF, 8'hFF, 8'hFF};
    out_sel = 24'hEDCB54; // fifo zero empty/full, chain cond, ctl 0..2
    alu_exp = '{8'h5A, 8'h5B, 8'h59, 8'h69, 8'h4B, 8'h0A, 8'h5F, 8'h55};
    sh_exp = '{8'hB4, 8'h2D, 8'hA5, 8'hFF};
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    // reset state
    chk8(acc0 | acc1 | dat0 | dat1, 8'h00);
    chk6({2'h0, fifo_flags}, 6'h05);
    chk6(route_out, 6'h01);
    chk6({2'h0, out_sel0}, 6'h04);
    // working registers by bus
    bus_u.wr(3'h0, 8'h5A);
    bus_u.wr(3'h1, 8'h3C);
    bus_u.wr(3'h2, 8'h0F);
    bus_u.wr(3'h3, 8'hC3);
    chk8(acc0, 8'h5A);
    chk8(acc1, 8'h3C);
    chk8(dat0, 8'h0F);
    chk8(dat1, 8'hC3);
    // every alu operation from its own config word
    for (int i = 0; i < 8; i++) begin
      ld(3'(i), cw(3'(i), cbd_pkg::SH_NONE, cbd_pkg::SEL_ACC0,
        cbd_pkg::SEL_DATA0, cbd_pkg::DST_ACC1));
    end
    for (int i = 0; i < 8; i++) begin
      route_in[2:0] = 3'(i);
      cyc(3);
      chk8(acc1, alu_exp[i]);
    end
    // post stage modes on a passed operand
    for (int j = 0; j < 4; j++) begin
      ld(3'(j), cw(cbd_pkg::OP_PASS, 3'(j + 1), cbd_pkg::SEL_ACC0,
        cbd_pkg::SEL_DATA0, cbd_pkg::DST_ACC1));
      route_in[2:0] = 3'(j);
      cyc(3);
      chk8(acc1, sh_exp[j]);
    end
    // counter held by the datapath enable
    ld(3'h7, 16'h0000);
    route_in[2:0] = 3'h7;
    bus_u.wr(3'h1, 8'h10);
    ld(3'h5, cw(cbd_pkg::OP_INC, cbd_pkg::SH_NONE, cbd_pkg::SEL_ACC1,
      cbd_pkg::SEL_DATA0, cbd_pkg::DST_ACC1));
    route_in[2:0] = 3'h5;
    cyc(4);
    dp_en = 1'b0;
    v = acc1;
    cyc(5);
    chk8(acc1, v);
    dp_en = 1'b1;
    cyc(1);
    chk8(acc1, v + 8'h01);
    route_in[2:0] = 3'h7;
    cyc(2);
    // four-bit add cut at the msb, chained carry in, one crc step
    msb = 3'h3;
    ld(3'h2, cw(cbd_pkg::OP_ADD, cbd_pkg::SH_NONE, cbd_pkg::SEL_ACC0,
      cbd_pkg::SEL_DATA0, cbd_pkg::DST_ACC1));
    route_in[2:0] = 3'h2;
    cyc(3);
    chk8(acc1, 8'h09);
    chk6({4'h0, ch_cout, ch_sout}, 6'h03);
    msb = 3'h7;
    cin = 1'b1;
    ld(3'h3, cw(cbd_pkg::OP_ADD, cbd_pkg::SH_NONE, cbd_pkg::SEL_ACC0,
      cbd_pkg::SEL_DATA0, cbd_pkg::DST_ACC1)
      | (16'(cbd_pkg::CIN_CHAIN) << cbd_pkg::F_CIN_LSB));
    route_in[2:0] = 3'h3;
    cyc(3);
    chk8(acc1, 8'h6A);
    poly = 8'h07;
    route_in[3] = 1'b1;
    ld(3'h4, cw(cbd_pkg::OP_PASS, cbd_pkg::SH_NONE, cbd_pkg::SEL_ACC0,
      cbd_pkg::SEL_DATA0, cbd_pkg::DST_ACC1)
      | (16'h0001 << cbd_pkg::F_CRC_BIT));
    route_in[2:0] = 3'h4;
    cyc(3);
    chk8(acc1, 8'hB3);
    route_in = 6'h07;
    cin = 1'b0;
    cyc(2);
    // input fifo filled past full, then drained back to back
    for (int i = 0; i < 5; i++) begin
      bus_u.wr(3'h4, 8'h11 * 8'(i + 1));
    end
    chk6({2'h0, fifo_flags}, 6'h06);
    chk6(route_out, 6'h02);
    chk8(fz_rd, 8'h11);
    route_in[5] = 1'b1;
    for (int i = 0; i < 5; i++) begin
      cyc(1);
      chk8(dat0, 8'h11 * 8'((i < 4) ? i + 1 : 4));
    end
    route_in[5] = 1'b0;
    chk6({2'h0, fifo_flags}, 6'h05);
    // output fifo written by the datapath, read by the bus
    ld(3'h6, cw(cbd_pkg::OP_PASS, cbd_pkg::SH_NONE, cbd_pkg::SEL_ACC0,
      cbd_pkg::SEL_DATA0, cbd_pkg::DST_FIFO));
    route_in[2:0] = 3'h6;
    cyc(1);
    route_in[2:0] = 3'h7;
    cyc(3);
    chk8(fo_rd, 8'h5A);
    chk6({2'h0, fifo_flags}, 6'h01);
    bus_u.pop1();
    chk6({2'h0, fifo_flags}, 6'h05);
    // control bits and chained condition onto routing
    bus_u.ctl(8'h05);
    chk8(ctl_out, 8'h05);
    chk6(route_out, 6'h29);
    cond = 1'b1;
    cyc(1);
    chk6(route_out, 6'h2D);
    // one-cycle compare match held in bit 0 until read clears it
    sticky = 8'h01;
    cm0 = 8'h00;
    cyc(1);
    chk8({7'h00, ch_cond}, 8'h01);
    cm0 = 8'hFF;
    cyc(2);
    bus_u.srd();
    chk8(stat, 8'h51);
    bus_u.srd();
    chk8(stat, 8'h50);
    stop_test();
  end
endmodule
`default_nettype wire
